// >>> src/ccmc_defines.svh
// register offsets, field positions, reset values and counts for the can mode control block
// assumes a 32-bit apb slave; every register is one aligned word
`ifndef CCMC_DEFINES_SVH
`define CCMC_DEFINES_SVH

`define CCMC_OFS_MCR         12'h000
`define CCMC_OFS_MSR         12'h004
`define CCMC_OFS_IER         12'h008
`define CCMC_OFS_DGR         12'h00C
`define CCMC_OFS_PAGE        12'h010
`define CCMC_OFS_BITLEN      12'h014
`define CCMC_OFS_FILTACT     12'h018
`define CCMC_OFS_TXREQ       12'h01C
`define CCMC_OFS_FIFO        12'h020

`define CCMC_MCR_INIT_BIT    0
`define CCMC_MCR_SLEEP_BIT   1
`define CCMC_MCR_AWAKE_BIT   2
`define CCMC_MSR_INITACK_BIT 0
`define CCMC_MSR_SLPACK_BIT  1
`define CCMC_MSR_WAKE_BIT    2
`define CCMC_MSR_RX_BIT      3
`define CCMC_DGR_LISTEN_BIT  0
`define CCMC_DGR_LOOP_BIT    1
`define CCMC_FIFO_REL_BIT    2
`define CCMC_FIFO_OVR_BIT    3

`define CCMC_MCR_RESET       3'h2
`define CCMC_BITLEN_RESET    8'h14
`define CCMC_IDLE_BITS       4'hB
`define CCMC_FIFO_DEPTH      2'h3
`define CCMC_TX_MAILBOXES    2
`define CCMC_FILTER_BANKS    6
`define CCMC_PAGE_BITS       3

`endif

// >>> src/ccmc_pkg.sv
// types shared by the can mode control block
// assumes ccmc_defines.svh holds the numbers
package ccmc_pkg;
   typedef enum logic [1:0] {
      CCMC_SLEEP  = 2'b00,
      CCMC_INIT   = 2'b01,
      CCMC_SYNC   = 2'b10,
      CCMC_NORMAL = 2'b11
   } ccmc_mode_t;
endpackage

// >>> src/ccmc_mode_ctrl.sv
// operating-mode control of a can controller with an apb register port
// assumes a protocol core on the same clock that sends and receives single bits
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "ccmc_defines.svh"

module ccmc_mode_ctrl (
   input  wire logic        pclk,            // 20 mhz apb clock
   input  wire logic        presetn,         // async reset, active low
   input  wire logic        psel,            // apb select
   input  wire logic        penable,         // apb access phase
   input  wire logic        pwrite,          // apb direction
   input  wire logic [11:0] paddr,           // apb byte address
   input  wire logic [31:0] pwdata,          // apb write data
   output logic      [31:0] prdata,          // apb read data
   output logic             pready,          // apb ready
   output logic             pslverr,         // apb error on unmapped address
   input  wire logic        bus_rx_pin,      // can receive pin
   output logic             bus_tx_pin,      // can transmit pin
   input  wire logic        core_tx_bit,     // bit the core wants on the bus
   input  wire logic        core_msg_stored, // pulse: valid filtered frame received
   input  wire logic        core_tx_done,    // pulse: granted mailbox finished
   output logic             core_rx_bit,     // bit seen by the core
   output logic             core_enable,     // core may join bus activity
   output logic             core_ignore_ack, // loop-back: ack errors ignored
   output logic             core_tx_grant,   // scheduled mailbox may start
   output logic             core_tx_mailbox, // index of the scheduled mailbox
   output logic [5:0]       filter_active,   // per-bank activation bits
   output logic [2:0]       page_select,     // active register page
   output logic             wake_irq         // wake-up interrupt, level
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchroniser: stage one is read only by stage two
   logic rx_meta_q;
   logic rx_q;
   logic rx_prev_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_meta_q <= 1'b1;
         rx_q      <= 1'b1;
         rx_prev_q <= 1'b1;
      end else begin
         rx_meta_q <= bus_rx_pin;
         rx_q      <= rx_meta_q;
         rx_prev_q <= rx_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state and registers
   ccmc_pkg::ccmc_mode_t mode_q;
   logic       init_request_q;
   logic       sleep_request_q;
   logic       auto_wake_enable_q;
   logic       wake_irq_enable_q;
   logic       wake_pending_q;
   logic       listen_only_select_q;
   logic       self_loop_select_q;
   logic       from_sleep_q;
   logic [7:0] bit_len_q;
   logic [7:0] bit_cnt_q;
   logic [3:0] idle_cnt_q;
   logic [5:0] filter_bank_active_q;
   logic [2:0] page_q;
   logic [1:0] tx_pend_q;
   logic       tx_busy_q;
   logic       tx_idx_q;
   logic [1:0] fifo_lvl_q;
   logic       fifo_ovr_q;

   logic wr;
   logic rd_ok;
   logic bus_act;
   logic bit_tick;
   logic idle_seen;
   logic in_init;
   logic in_sleep;

   assign wr       = psel && penable && pwrite;
   assign in_init  = (mode_q == ccmc_pkg::CCMC_INIT);
   assign in_sleep = (mode_q == ccmc_pkg::CCMC_SLEEP);
   // any dominant edge while asleep counts as bus activity
   assign bus_act  = in_sleep && rx_prev_q && !rx_q;

   ////////////////////////////////////////////////////////////////////////////
   // bit-rate sample tick from the programmed bit length
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bit_cnt_q <= 8'h00;
      end else if (bit_tick || mode_q != ccmc_pkg::CCMC_SYNC) begin
         bit_cnt_q <= 8'h00;
      end else begin
         bit_cnt_q <= bit_cnt_q + 8'h01;
      end
   end
   assign bit_tick = (bit_cnt_q + 8'h01 >= bit_len_q);

   // idle detector: restart on dominant, count recessive samples
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idle_cnt_q <= 4'h0;
      end else if (mode_q != ccmc_pkg::CCMC_SYNC || !rx_q) begin
         idle_cnt_q <= 4'h0;
      end else if (bit_tick && idle_cnt_q != `CCMC_IDLE_BITS) begin
         idle_cnt_q <= idle_cnt_q + 4'h1;
      end
   end
   assign idle_seen = (idle_cnt_q == `CCMC_IDLE_BITS);

   ////////////////////////////////////////////////////////////////////////////
   // mode machine; init has priority over sleep in normal mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q       <= ccmc_pkg::CCMC_SLEEP;
         from_sleep_q <= 1'b1;
      end else begin
         unique case (mode_q)
            ccmc_pkg::CCMC_SLEEP: begin
               // mode held while asleep: a pending init request waits
               if (!sleep_request_q) begin
                  mode_q       <= ccmc_pkg::CCMC_SYNC;
                  from_sleep_q <= 1'b1;
               end
            end
            ccmc_pkg::CCMC_INIT: begin
               // configuration registers are not touched on entry
               if (!init_request_q) begin
                  mode_q       <= ccmc_pkg::CCMC_SYNC;
                  from_sleep_q <= 1'b0;
               end
            end
            ccmc_pkg::CCMC_SYNC: begin
               if (init_request_q) begin
                  mode_q <= ccmc_pkg::CCMC_INIT;
               end else if (idle_seen) begin
                  mode_q <= ccmc_pkg::CCMC_NORMAL;
               end
            end
            ccmc_pkg::CCMC_NORMAL: begin
               if (init_request_q) begin
                  mode_q <= ccmc_pkg::CCMC_INIT;
               end else if (sleep_request_q) begin
                  mode_q <= ccmc_pkg::CCMC_SLEEP;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // master control reset word, split into its fields below
   localparam logic [2:0] MCR_RST = `CCMC_MCR_RESET;

   // master control: hardware wake clears the sleep request after a write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         init_request_q     <= MCR_RST[`CCMC_MCR_INIT_BIT];
         sleep_request_q    <= MCR_RST[`CCMC_MCR_SLEEP_BIT];
         auto_wake_enable_q <= MCR_RST[`CCMC_MCR_AWAKE_BIT];
      end else begin
         if (wr && paddr == `CCMC_OFS_MCR) begin
            init_request_q     <= pwdata[`CCMC_MCR_INIT_BIT];
            sleep_request_q    <= pwdata[`CCMC_MCR_SLEEP_BIT];
            auto_wake_enable_q <= pwdata[`CCMC_MCR_AWAKE_BIT];
         end
         if (bus_act && auto_wake_enable_q) begin
            sleep_request_q <= 1'b0;
         end
      end
   end

   // wake flag: set beats a software clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_pending_q <= 1'b0;
      end else if (bus_act) begin
         wake_pending_q <= 1'b1;
      end else if (wr && paddr == `CCMC_OFS_MSR && pwdata[`CCMC_MSR_WAKE_BIT]) begin
         wake_pending_q <= 1'b0;
      end
   end
   assign wake_irq = wake_pending_q && wake_irq_enable_q;

   // configuration registers; software keeps test bits to init mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_irq_enable_q    <= 1'b0;
         listen_only_select_q <= 1'b0;
         self_loop_select_q   <= 1'b0;
         bit_len_q            <= `CCMC_BITLEN_RESET;
         filter_bank_active_q               <= 6'h00;
         page_q               <= 3'h0;
      end else if (wr) begin
         unique case (paddr)
            `CCMC_OFS_IER:    wake_irq_enable_q <= pwdata[0];
            `CCMC_OFS_DGR: begin
               listen_only_select_q <= pwdata[`CCMC_DGR_LISTEN_BIT];
               self_loop_select_q   <= pwdata[`CCMC_DGR_LOOP_BIT];
            end
            `CCMC_OFS_PAGE:   page_q    <= pwdata[2:0];
            `CCMC_OFS_BITLEN: bit_len_q <= (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
            `CCMC_OFS_FILTACT: filter_bank_active_q   <= pwdata[5:0];
            default: ;
         endcase
      end
   end
   assign filter_active = filter_bank_active_q;
   assign page_select   = page_q;

   ////////////////////////////////////////////////////////////////////////////
   // two transmit mailboxes; lower pending index goes first
   // a finish and a new request in one cycle must both land; the request wins
   logic [1:0] tx_clr;
   logic [1:0] tx_set;
   assign tx_clr = (tx_busy_q && core_tx_done) ? (2'h1 << tx_idx_q) : 2'h0;
   assign tx_set = (wr && paddr == `CCMC_OFS_TXREQ) ? pwdata[1:0] : 2'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_pend_q <= 2'h0;
         tx_busy_q <= 1'b0;
         tx_idx_q  <= 1'b0;
      end else begin
         tx_pend_q <= (tx_pend_q & ~tx_clr) | tx_set;
         if (tx_busy_q && core_tx_done) begin
            tx_busy_q <= 1'b0;
         end else if (!tx_busy_q && core_tx_grant) begin
            tx_busy_q <= 1'b1;
            tx_idx_q  <= core_tx_mailbox;
         end
      end
   end
   assign core_tx_mailbox = tx_busy_q ? tx_idx_q : !tx_pend_q[0];
   // listen-only never starts a frame
   assign core_tx_grant   = (tx_busy_q || tx_pend_q != 2'h0)
                            && core_enable && !listen_only_select_q;

   ////////////////////////////////////////////////////////////////////////////
   // receive fifo occupancy, at most three messages held in all
   // a release of an empty fifo is ignored so the level never wraps
   logic fifo_rel;
   assign fifo_rel = wr && paddr == `CCMC_OFS_FIFO && pwdata[`CCMC_FIFO_REL_BIT]
                     && fifo_lvl_q != 2'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fifo_lvl_q <= 2'h0;
         fifo_ovr_q <= 1'b0;
      end else begin
         if (core_msg_stored && !fifo_rel && fifo_lvl_q == `CCMC_FIFO_DEPTH) begin
            fifo_ovr_q <= 1'b1;
         end else if (wr && paddr == `CCMC_OFS_FIFO && pwdata[`CCMC_FIFO_OVR_BIT]) begin
            fifo_ovr_q <= 1'b0;
         end
         if (core_msg_stored && !fifo_rel && fifo_lvl_q != `CCMC_FIFO_DEPTH) begin
            fifo_lvl_q <= fifo_lvl_q + 2'h1;
         end else if (fifo_rel && !core_msg_stored) begin
            fifo_lvl_q <= fifo_lvl_q - 2'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin muxing for normal, listen-only and loop-back
   assign core_enable     = (mode_q == ccmc_pkg::CCMC_NORMAL);
   assign core_ignore_ack = self_loop_select_q;
   always_comb begin
      if (!core_enable || listen_only_select_q) begin
         bus_tx_pin = 1'b1;
      end else begin
         bus_tx_pin = core_tx_bit;
      end
      if (self_loop_select_q) begin
         core_rx_bit = core_tx_bit;
      end else if (listen_only_select_q) begin
         core_rx_bit = rx_q & core_tx_bit;
      end else begin
         core_rx_bit = rx_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb read side, zero wait states
   logic init_ack;
   logic slp_ack;
   assign init_ack = in_init || (mode_q == ccmc_pkg::CCMC_SYNC && !from_sleep_q);
   assign slp_ack  = in_sleep || (mode_q == ccmc_pkg::CCMC_SYNC && from_sleep_q);

   always_comb begin
      prdata = 32'h0000_0000;
      rd_ok  = 1'b1;
      unique case (paddr)
         `CCMC_OFS_MCR:    prdata[2:0] = {auto_wake_enable_q, sleep_request_q, init_request_q};
         `CCMC_OFS_MSR:    prdata[3:0] = {rx_q, wake_pending_q, slp_ack, init_ack};
         `CCMC_OFS_IER:    prdata[0]   = wake_irq_enable_q;
         `CCMC_OFS_DGR:    prdata[2:0] = {rx_q, self_loop_select_q, listen_only_select_q};
         `CCMC_OFS_PAGE:   prdata[2:0] = page_q;
         `CCMC_OFS_BITLEN: prdata[7:0] = bit_len_q;
         `CCMC_OFS_FILTACT: prdata[5:0] = filter_bank_active_q;
         `CCMC_OFS_TXREQ:  prdata[3:0] = {tx_idx_q, tx_busy_q, tx_pend_q};
         `CCMC_OFS_FIFO:   prdata[3:0] = {fifo_ovr_q, 1'b0, fifo_lvl_q};
         default:          rd_ok       = 1'b0;
      endcase
   end
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !rd_ok;

endmodule

// >>> test/ccmc_sva.sv
// concurrent checks for the can mode control block, seen from its ports only
// assumes apb writes take effect at the access edge and the reset bit length stays in use
`timescale 1ns/1ps

module ccmc_sva (
   input wire logic        pclk,            // apb clock
   input wire logic        presetn,         // async reset, active low
   input wire logic        psel,            // apb select
   input wire logic        penable,         // apb access phase
   input wire logic        pwrite,          // apb direction
   input wire logic [11:0] paddr,           // apb address
   input wire logic [31:0] pwdata,          // apb write data
   input wire logic        pready,          // apb ready
   input wire logic        bus_rx_pin,      // can receive pin
   input wire logic        bus_tx_pin,      // can transmit pin
   input wire logic        core_tx_bit,     // core bit
   input wire logic        core_rx_bit,     // bit seen by core
   input wire logic        core_enable,     // normal mode
   input wire logic        core_ignore_ack, // loop-back
   input wire logic        core_tx_grant,   // mailbox may start
   input wire logic [5:0]  filter_active,   // bank activation
   input wire logic [2:0]  page_select,     // register page
   input wire logic        wake_irq         // wake interrupt
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ten bit times at the reset bit length; one bit of slack for sampling phase
   localparam int MIN_IDLE = 200;
   logic        wr;
   logic        listen_q;
   logic        loop_q;
   logic        irq_en_q;
   logic [15:0] rcnt_q;
   assign wr = psel & penable & pwrite & pready;
   ////////////////////////////////////////////////////////////////////////////////
   // shadow of the test bits as software wrote them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         listen_q <= 1'b0;
         loop_q <= 1'b0;
      end else if (wr && paddr == 12'h00C) begin
         listen_q <= pwdata[0];
         loop_q <= pwdata[1];
      end
   end
   // shadow of the wake interrupt enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) irq_en_q <= 1'b0;
      else if (wr && paddr == 12'h008) irq_en_q <= pwdata[0];
   end
   // recessive run length on the wire; saturates so a long idle never wraps to zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) rcnt_q <= 16'h0000;
      else if (!bus_rx_pin) rcnt_q <= 16'h0000;
      else if (rcnt_q != 16'hFFFF) rcnt_q <= rcnt_q + 16'h0001;
   end
   ////////////////////////////////////////////////////////////////////////////////
   sequence page_wr;
      wr && paddr == 12'h010;
   endsequence
   sequence filt_wr;
      wr && paddr == 12'h018;
   endsequence
   reset_sleep_a: assert property ($rose(presetn) |-> !core_enable)
      else $error("block left reset outside low-power mode");
   quiet_tx_a: assert property (!core_enable |-> bus_tx_pin && !core_tx_grant)
      else $error("bus driven or grant given outside normal mode");
   normal_link_a: assert property (core_enable && !listen_q |-> bus_tx_pin == core_tx_bit)
      else $error("normal mode does not pass the core bit to the bus");
   idle_wait_a: assert property ($rose(core_enable) |-> rcnt_q >= MIN_IDLE)
      else $error("normal mode entered without bus idle");
   listen_tx_a: assert property (listen_q |-> bus_tx_pin)
      else $error("listen-only drives a dominant bit");
   listen_loop_a: assert property (listen_q && !core_tx_bit |-> !core_rx_bit)
      else $error("dominant core bit not looped back in listen-only");
   self_loop_a: assert property (loop_q |-> core_rx_bit == core_tx_bit && core_ignore_ack)
      else $error("loop-back path or ack ignore missing");
   page_sel_a: assert property (page_wr |=> page_select == $past(pwdata[2:0]))
      else $error("page select not taken from write");
   filter_act_a: assert property (filt_wr |=> filter_active == $past(pwdata[5:0]))
      else $error("filter activation not taken from write");
   wake_gate_a: assert property (wake_irq |-> irq_en_q)
      else $error("wake interrupt without enable");
endmodule

bind ccmc_mode_ctrl ccmc_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .bus_rx_pin(bus_rx_pin), .bus_tx_pin(bus_tx_pin), .core_tx_bit(core_tx_bit),
   .core_rx_bit(core_rx_bit), .core_enable(core_enable), .core_ignore_ack(core_ignore_ack),
   .core_tx_grant(core_tx_grant), .filter_active(filter_active),
   .page_select(page_select), .wake_irq(wake_irq));

// >>> test/ccmc_bus_node.sv
// model of the other nodes on the can wire: a wired-and bus with pull-up
// assumes the bench asks for single dominant bits by a one-cycle send pulse
`timescale 1ns/1ps

module ccmc_bus_node #(
   parameter int BIT_CYC = 20 // pclk cycles in one bit
) (
   input  wire logic pclk,    // clock
   input  wire logic presetn, // reset, active low
   input  wire logic dut_tx,  // transmit pin of the block
   input  wire logic send,    // pulse: put one dominant bit on the wire
   output logic      bus      // wire level seen by every node
);
   int cnt_q;
   // dominant bit timer; the wire idles recessive through the pull-up
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) cnt_q <= 0;
      else if (send) cnt_q <= BIT_CYC;
      else if (cnt_q > 0) cnt_q <= cnt_q - 1;
   end
   assign bus = dut_tx & (cnt_q == 0); // any dominant driver wins
endmodule

// >>> test/tb_can_controller_mode_control.sv
// self-checking bench for the can mode control block
// assumes the bus node model and the bound checker are compiled with it
`timescale 1ns/1ps

module tb_can_controller_mode_control;
   logic        pclk, presetn, psel, penable, pwrite, core_tx_bit, core_tx_done, send, e, stored;
   logic [11:0] paddr;
   logic [31:0] pwdata, q, prdata;
   logic        pready, pslverr, bus_rx_pin, bus_tx_pin, core_rx_bit, core_enable, wake_irq;
   logic        core_ignore_ack, core_tx_grant, core_tx_mailbox;
   logic [5:0]  filter_active;
   logic [2:0]  page_select;
   int          failures = 0, checked = 0, cyc = 0;

   ccmc_mode_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .bus_rx_pin(bus_rx_pin), .bus_tx_pin(bus_tx_pin),
      .core_tx_bit(core_tx_bit), .core_msg_stored(stored), .core_tx_done(core_tx_done),
      .core_rx_bit(core_rx_bit), .core_enable(core_enable), .core_ignore_ack(core_ignore_ack),
      .core_tx_grant(core_tx_grant), .core_tx_mailbox(core_tx_mailbox),
      .filter_active(filter_active), .page_select(page_select), .wake_irq(wake_irq));
   ccmc_bus_node #(.BIT_CYC(20)) node (.pclk(pclk), .presetn(presetn), .dut_tx(bus_tx_pin),
      .send(send), .bus(bus_rx_pin));
   ////////////////////////////////////////////////////////////////////////////////
   // 20 mhz clock
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // hang guard; the full run needs well under this many cycles
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 30000) begin
         failures++;
         $display("[FAIL] %0t run did not finish in time", $time);
         end_sim();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // one apb transfer; holds the request until pready is seen at an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      checked++;
      if (g !== x) begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, g, x);
      end
   endtask
   // reads until the masked field matches or the try count runs out, then compares
   task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      for (int i = 0; i < 400 && (q & m) !== x; i++) apb(1'b0, a, 32'h0);
      chk(q & m, x);
   endtask
   task automatic dom_bit();
      @(posedge pclk);
      send <= 1'b1;
      @(posedge pclk);
      send <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      apb(1'b0, 12'h004, 32'h0);
      chk(q[1:0], 2'b10);
      chk(core_enable, 1'b0);
      chk(bus_tx_pin, 1'b1);
      apb(1'b0, 12'h040, 32'h0);
      chk(e, 1'b1);
      $display("test reset done");
   endtask
   // init request made in sleep stays unanswered; a software wake then reaches init
   task automatic t_sleep_init();
      apb(1'b1, 12'h010, 32'h5);
      apb(1'b1, 12'h018, 32'h2A);
      apb(1'b1, 12'h000, 32'h3);
      repeat (40) @(posedge pclk);
      apb(1'b0, 12'h004, 32'h0);
      chk(q[1:0], 2'b10);
      apb(1'b1, 12'h000, 32'h1);
      poll(12'h004, 32'h3, 32'h1);
      apb(1'b0, 12'h010, 32'h0);
      chk(q, 32'h5);
      apb(1'b0, 12'h018, 32'h0);
      chk(q, 32'h2A);
      apb(1'b1, 12'h018, 32'h0);
      apb(1'b1, 12'h014, 32'h14);
      apb(1'b1, 12'h018, 32'h2A);
      apb(1'b0, 12'h014, 32'h0);
      chk(q, 32'h14);
      $display("test sleep and init done");
   endtask
   // a dominant bit during synchronisation restarts the idle count
   task automatic t_leave_init();
      int t0;
      apb(1'b1, 12'h000, 32'h0);
      repeat (100) @(posedge pclk);
      dom_bit();
      t0 = cyc;
      poll(12'h004, 32'h3, 32'h0);
      chk(cyc - t0 >= 220, 1'b1);
      chk(core_enable, 1'b1);
      $display("test leave init done");
   endtask
   task automatic t_normal();
      core_tx_bit <= 1'b0;
      @(posedge pclk);
      chk(bus_tx_pin, 1'b0);
      core_tx_bit <= 1'b1;
      apb(1'b1, 12'h01C, 32'h3);
      for (int i = 0; i < 20 && core_tx_grant !== 1'b1; i++) @(posedge pclk);
      chk(core_tx_grant, 1'b1);
      chk(core_tx_mailbox, 1'b0);
      for (int k = 0; k < 2; k++) begin
         @(posedge pclk);
         core_tx_done <= 1'b1;
         @(posedge pclk);
         core_tx_done <= 1'b0;
         repeat (3) @(posedge pclk);
         if (k == 0) chk(core_tx_mailbox, 1'b1);
         else chk(core_tx_grant, 1'b0);
      end
      $display("test normal done");
   endtask
   // listen-only, loop-back, both, then back to plain normal
   task automatic t_tests();
      logic [1:0] m;
      for (int k = 1; k < 5; k++) begin
         m = k[1:0];
         apb(1'b1, 12'h000, 32'h1);
         poll(12'h004, 32'h3, 32'h1);
         apb(1'b1, 12'h00C, {30'h0, m});
         apb(1'b1, 12'h000, 32'h0);
         poll(12'h004, 32'h3, 32'h0);
         core_tx_bit <= 1'b0;
         @(posedge pclk);
         if (m != 2'b00) chk(core_rx_bit, 1'b0);
         if (m[0]) chk(bus_tx_pin, 1'b1);
         chk(core_ignore_ack, m[1]);
         core_tx_bit <= 1'b1;
      end
      $display("test modes done");
   endtask
   // three messages fill the fifo, a fourth overruns; release and clear step back
   task automatic t_fifo();
      repeat (4) begin
         @(posedge pclk);
         stored <= 1'b1;
         @(posedge pclk);
         stored <= 1'b0;
      end
      apb(1'b0, 12'h020, 32'h0);
      chk(q[3:0], 4'hB);
      apb(1'b1, 12'h020, 32'hC);
      apb(1'b0, 12'h020, 32'h0);
      chk(q[3:0], 4'h2);
      $display("test fifo done");
   endtask
   // bus activity wakes the block, clears the sleep request and raises the interrupt
   task automatic t_wake();
      apb(1'b1, 12'h008, 32'h1);
      apb(1'b1, 12'h000, 32'h6);
      poll(12'h004, 32'h3, 32'h2);
      dom_bit();
      repeat (8) @(posedge pclk);
      chk(wake_irq, 1'b1);
      apb(1'b0, 12'h000, 32'h0);
      chk(q[1], 1'b0);
      poll(12'h004, 32'h3, 32'h0);
      apb(1'b1, 12'h004, 32'h4);
      @(posedge pclk);
      chk(wake_irq, 1'b0);
      $display("test wake done");
   endtask
   task automatic end_sim();
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      {presetn, psel, penable, pwrite, core_tx_done, send, e, stored} = 8'h00;
      core_tx_bit = 1'b1;
      paddr = 12'h000;
      pwdata = 32'h0;
      q = 32'h0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_sleep_init();
      t_leave_init();
      t_normal();
      t_tests();
      t_fifo();
      t_wake();
      end_sim();
   end
endmodule
